// File: tb_top.sv
// Self-checking bench for the 16-bit timer with capture unit
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CB = tmr_pkg::ADDR_CTRL_B;
    localparam logic [7:0] CNT = tmr_pkg::ADDR_COUNT_LO;
    localparam logic [7:0] CAP = tmr_pkg::ADDR_CAPT_LO;
    localparam logic [7:0] FLG = tmr_pkg::ADDR_FLAGS;
    logic i_clock = 0, i_rst_n = 0, ext = 0, pin = 0, comp = 0;
    logic cack = 0, oack = 0, pend = 0, cirq, oirq, top, bot;
    logic [7:0] rdata;
    logic [15:0] n;
    tmr_pkg::tmr_bus_s bus;
    int num_errors = 0, check_count = 0, cycles = 0;
    logic [15:0] tops [16] = '{16'hFFFF, 16'h00FF, 16'h01FF, 16'h03FF,
        16'h0345, 16'h00FF, 16'h01FF, 16'h03FF, 16'h0456, 16'h0345,
        16'h0456, 16'h0345, 16'h0456, 16'hFFFF, 16'h0456, 16'h0345};
    tmr_cpu i_tmr_cpu (.i_clock(i_clock), .o_bus(bus));
    tmr_timer16 i_tmr_timer16 (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_bus(bus), .i_ext_clock(ext), .i_capture_pin(pin),
        .i_comparator_output(comp), .i_capture_irq_ack(cack),
        .i_overflow_irq_ack(oack), .o_rdata(rdata), .o_capture_irq(cirq),
        .o_overflow_irq(oirq), .o_at_top(top), .o_at_bottom(bot));
    initial forever #50 i_clock = ~i_clock;
    task automatic check(input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Read data answered in the cycle after each read strobe
    always @(posedge i_clock) begin
        pend <= bus.rd;
        if (pend) begin
            n = i_tmr_cpu.notes.pop_front();
            check(rdata & n[15:8], n[7:0] & n[15:8]);
        end
    end
    // Hang guard
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        int k, j;
        logic [15:0] v;
        k = $urandom(6204);
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        // Reset state and an unmapped address
        i_tmr_cpu.rd16(CNT, 16'h0000);
        i_tmr_cpu.rd(8'h0F, 8'h00);
        check(bot, 1'b1);
        $display("Test reset done");
        // Random loads with no tick source, then one shared high byte
        repeat (4) begin
            v = 16'($urandom());
            i_tmr_cpu.wr16(CNT, v);
            repeat (3) @(posedge i_clock);
            i_tmr_cpu.rd16(CNT, v);
        end
        i_tmr_cpu.wr16(tmr_pkg::ADDR_CMPA_LO, 16'h0345);
        i_tmr_cpu.wr(CNT, 8'h77);
        i_tmr_cpu.rd16(CNT, 16'h0377);
        $display("Test access done");
        // TOP of every mode, checked on and just below it
        i_tmr_cpu.wr(CB, 8'h18);
        i_tmr_cpu.wr16(CAP, 16'h0456);
        for (k = 0; k < 16; k++) begin
            i_tmr_cpu.wr(tmr_pkg::ADDR_CTRL_A, {6'h00, k[1:0]});
            i_tmr_cpu.wr(CB, {3'h0, k[3:2], 3'h0});
            i_tmr_cpu.wr16(CNT, tops[k]);
            #1 check(top, 1'b1);
            i_tmr_cpu.wr16(CNT, tops[k] - 16'h0001);
            #1 check(top, 1'b0);
        end
        i_tmr_cpu.wr16(CAP, 16'h1111);
        i_tmr_cpu.rd16(CAP, 16'h0456);
        $display("Test top done");
        // Up count wraps and flags overflow, ack clears it
        i_tmr_cpu.wr(tmr_pkg::ADDR_CTRL_A, 8'h00);
        i_tmr_cpu.wr(tmr_pkg::ADDR_MASK, 8'h21);
        i_tmr_cpu.wr16(CNT, 16'hFFF0);
        i_tmr_cpu.wr(CB, 8'h01);
        for (j = 0; j < 40 && oirq !== 1'b1; j++) @(posedge i_clock);
        check(oirq, 1'b1);
        i_tmr_cpu.wr(CB, 8'h00);
        i_tmr_cpu.rd(CNT, 8'h00, 8'hE0);
        oack <= 1'b1;
        @(posedge i_clock);
        oack <= 1'b0;
        #1 check(oirq, 1'b0);
        // Dual slope: up to TOP, down to BOTTOM, overflow there
        i_tmr_cpu.wr(tmr_pkg::ADDR_CTRL_A, 8'h01);
        i_tmr_cpu.wr16(CNT, 16'h00F0);
        i_tmr_cpu.wr(CB, 8'h01);
        for (j = 0; j < 40 && top !== 1'b1; j++) @(posedge i_clock);
        check(top, 1'b1);
        for (j = 0; j < 300 && bot !== 1'b1; j++) @(posedge i_clock);
        check(bot, 1'b1);
        #1 check(oirq, 1'b1);
        $display("Test count done");
        // Rising capture with the filter off then on: four more cycles
        i_tmr_cpu.wr(tmr_pkg::ADDR_CTRL_A, 8'h00);
        for (k = 0; k < 2; k++) begin
            pin <= 1'b0;
            i_tmr_cpu.wr(CB, k[0] ? 8'hC1 : 8'h41);
            i_tmr_cpu.wr(FLG, 8'h20);
            i_tmr_cpu.wr16(CNT, 16'h0000);
            pin <= 1'b1;
            for (j = 0; j < 20 && cirq !== 1'b1; j++) @(posedge i_clock);
            check(cirq, 1'b1);
            i_tmr_cpu.rd(CAP, k[0] ? 8'h06 : 8'h02);
        end
        i_tmr_cpu.wr(FLG, 8'h20);
        #1 check(cirq, 1'b0);
        // Falling edge, filtered glitch ignored, capture overwrites
        i_tmr_cpu.wr(CB, 8'h80);
        i_tmr_cpu.wr(FLG, 8'h20);
        i_tmr_cpu.wr16(CNT, 16'h0ABC);
        pin <= 1'b0;
        repeat (2) @(posedge i_clock);
        pin <= 1'b1;
        repeat (12) @(posedge i_clock);
        check(cirq, 1'b0);
        pin <= 1'b0;
        for (j = 0; j < 20 && cirq !== 1'b1; j++) @(posedge i_clock);
        check(cirq, 1'b1);
        i_tmr_cpu.rd16(CAP, 16'h0ABC);
        cack <= 1'b1;
        @(posedge i_clock);
        cack <= 1'b0;
        #1 check(cirq, 1'b0);
        $display("Test capture done");
        // Comparator source captures; capture-as-TOP mode blocks it
        i_tmr_cpu.wr(tmr_pkg::ADDR_COMP_CTRL, 8'h04);
        i_tmr_cpu.wr(CB, 8'h40);
        i_tmr_cpu.wr(FLG, 8'h20);
        comp <= 1'b1;
        for (j = 0; j < 20 && cirq !== 1'b1; j++) @(posedge i_clock);
        check(cirq, 1'b1);
        i_tmr_cpu.wr(CB, 8'h58);
        i_tmr_cpu.wr(FLG, 8'h20);
        comp <= 1'b0;
        repeat (4) @(posedge i_clock);
        comp <= 1'b1;
        repeat (12) @(posedge i_clock);
        check(cirq, 1'b0);
        // External pin ticks on its rising edge only
        i_tmr_cpu.wr(CB, 8'h07);
        i_tmr_cpu.wr16(CNT, 16'h0000);
        repeat (3) begin
            ext <= 1'b1;
            repeat (3) @(posedge i_clock);
            ext <= 1'b0;
            repeat (3) @(posedge i_clock);
        end
        i_tmr_cpu.rd16(CNT, 16'h0003);
        // Power-off freezes the count; a write beats a tick
        i_tmr_cpu.wr(CB, 8'h01);
        i_tmr_cpu.wr(tmr_pkg::ADDR_POWER, 8'h01);
        i_tmr_cpu.wr16(CNT, 16'h1234);
        repeat (10) @(posedge i_clock);
        i_tmr_cpu.rd16(CNT, 16'h1234);
        i_tmr_cpu.wr(tmr_pkg::ADDR_POWER, 8'h00);
        i_tmr_cpu.wr16(CNT, 16'h2000);
        i_tmr_cpu.rd(CNT, 8'h00, 8'hC0);
        $display("Test power done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire

// File: tmr_cpu.sv
// Processor model driving the timer's byte register bus
`default_nettype none
module tmr_cpu (
    input  wire logic               i_clock,
    output var  tmr_pkg::tmr_bus_s  o_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] notes [$]; // Mask in high byte, expected byte in low
    initial o_bus = '0;
    // One strobe cycle, then back to idle
    task automatic cycle(input logic [7:0] a, d, input logic w);
        @(posedge i_clock);
        o_bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge i_clock);
        o_bus <= '0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        cycle(a, d, 1'b1);
    endtask
    // Read, noting the expected byte and the bits that matter
    task automatic rd(input logic [7:0] a, e, input logic [7:0] m = 8'hFF);
        notes.push_back({m, e});
        cycle(a, 8'h00, 1'b0);
    endtask
    // High byte through the shared temp first, low byte loads all
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask
    // Low byte first so the high byte is latched into temp
    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rd(a, e[7:0]);
        rd(a + 8'h01, e[15:8]);
    endtask
endmodule // tmr_cpu
`default_nettype wire

// File: tmr_pkg.sv
// Shared constants and types for the 16-bit timer with capture unit
`default_nettype none
package tmr_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL_A    = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B    = 8'h01;
    localparam logic [7:0] ADDR_COUNT_LO  = 8'h02;
    localparam logic [7:0] ADDR_COUNT_HI  = 8'h03;
    localparam logic [7:0] ADDR_CAPT_LO   = 8'h04;
    localparam logic [7:0] ADDR_CAPT_HI   = 8'h05;
    localparam logic [7:0] ADDR_CMPA_LO   = 8'h06;
    localparam logic [7:0] ADDR_CMPA_HI   = 8'h07;
    localparam logic [7:0] ADDR_FLAGS     = 8'h08;
    localparam logic [7:0] ADDR_MASK      = 8'h09;
    localparam logic [7:0] ADDR_COMP_CTRL = 8'h0A;
    localparam logic [7:0] ADDR_POWER     = 8'h0B;
    // Field positions
    localparam int CTRL_B_FILTER  = 7;
    localparam int CTRL_B_EDGE    = 6;
    localparam int CTRL_B_MODE_LO = 3;
    localparam int CTRL_B_CS_LO   = 0;
    localparam int FLAG_OVF       = 0;
    localparam int FLAG_CAPT      = 5;
    localparam int COMP_SEL       = 2;
    localparam int POWER_OFF      = 0;
    // Reset values
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic        POWER_RESET = 1'b0;
    // Fixed TOP values and counter limits
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_BOT = 16'h0000;
    // Prescaler terminal masks
    localparam logic [9:0] PRE_DIV8    = 10'h007;
    localparam logic [9:0] PRE_DIV64   = 10'h03F;
    localparam logic [9:0] PRE_DIV256  = 10'h0FF;
    localparam logic [9:0] PRE_DIV1024 = 10'h3FF;
    // Noise filter sample count
    localparam int FILTER_SAMPLES = 4;
    // Clock select codes
    typedef enum logic [2:0] {
        CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64,
        CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
    } tmr_clock_sel_e;
    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tmr_bus_s;
endpackage
`default_nettype wire

// File: tmr_timer16.sv
// 16-bit up/down timer with input capture, noise filter and byte bus
//
// Functional notes
// RL1: One shared high-byte temp lets software load a common high byte once.
// RL2: Three-bit clock select picks tick source; zero stops the counter.
// RL3: 16-bit counter steps up or down by one, or clears, per tick.
// RL4: Top and bottom indications come from the counter value.
// RL5: Count low read latches high byte; low write loads all 16 bits.
// RL6: Processor counter write beats any step or clear that cycle.
// RL7: Counter stays readable and writable with no tick source.
// RL8: Four-bit waveform mode, split over controls A and B, sets sequence.
// RL9: Overflow flag set per mode and can request an interrupt.
// RL10: Qualified capture edge copies the whole counter into capture value.
// RL11: Capture flag sets in the same cycle the capture value is written.
// RL12: Capture flag requests interrupt when enabled; cleared by ack or one.
// RL13: Capture low read fills temp; capture high read returns temp.
// RL14: Capture value writable only in modes using it as top.
// RL15: Comparator select bit swaps the capture source from the pin.
// RL16: Sources synchronised and edge detected; filter adds four cycles.
// RL17: Capture triggering disabled in modes where capture value is top.
// RL18: Driving the capture pin from the port output can trigger capture.
// RL19: Filter output changes only after four agreeing samples.
// RL20: Filter enable in control B; filter runs on the system clock.
// RL21: Each capture overwrites the previous value; no overrun guard.
// RL22: Software flips edge and clears flag for duty-cycle measurement.
// RL23: Top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture value.
// RL24: All 16-bit registers share one 8-bit temporary high byte.
// RL25: Power-off bit at one holds the timer disabled.
// RL26: Edge select bit: one picks rising edge, zero falling edge.
`default_nettype none
module tmr_timer16 (
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire tmr_pkg::tmr_bus_s i_bus,
    input  wire logic             i_ext_clock,
    input  wire logic             i_capture_pin,
    input  wire logic             i_comparator_output,
    input  wire logic             i_capture_irq_ack,
    input  wire logic             i_overflow_irq_ack,
    output logic [7:0]            o_rdata,
    output logic                  o_capture_irq,
    output logic                  o_overflow_irq,
    output logic                  o_at_top,
    output logic                  o_at_bottom
);
    logic [7:0]  timer_control_a;
    logic [7:0]  timer_control_b;
    logic [15:0] count_value;
    logic [15:0] capture_value;
    logic [15:0] compare_a_value;
    logic [7:0]  temp_high;
    logic        overflow_flag;
    logic        capture_flag;
    logic        overflow_irq_enable;
    logic        capture_irq_enable;
    logic        comparator_capture_select;
    logic        timer_power_off_bit;
    logic        count_up;
    logic [9:0]  prescale;
    logic [1:0]  ext_sync;
    logic        ext_prev;
    logic [1:0]  capt_sync;
    logic [tmr_pkg::FILTER_SAMPLES-2:0] filter_hist;
    logic        filter_out;
    logic        edge_prev;
    logic [3:0]  waveform_mode_field;
    logic [2:0]  clock_select_field;
    logic        capture_filter_enable;
    logic        edge_rising;
    logic        timer_tick;
    logic [15:0] top_value;
    logic        edge_src;
    logic        capture_event;
    logic        wr_count;
    logic        wr_capture;
    logic        overflow_set;
    logic        filter_agree;
    logic [15:0] next_count;
    logic        next_up;

    // Mode is fixed-top via capture value
    function automatic logic capt_is_top(input logic [3:0] mode);
        return (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) ||
               (mode == 4'hE);
    endfunction

    // Dual-slope (phase correct) modes
    function automatic logic is_dual(input logic [3:0] mode);
        return (mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
    endfunction

    // Single-slope fast PWM modes
    function automatic logic is_fast(input logic [3:0] mode);
        return (mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
    endfunction

    // Field decode from the control registers
    assign waveform_mode_field = {timer_control_b[tmr_pkg::CTRL_B_MODE_LO+1],
                                  timer_control_b[tmr_pkg::CTRL_B_MODE_LO],
                                  timer_control_a[1:0]};  // see RL8
    assign clock_select_field =
        timer_control_b[tmr_pkg::CTRL_B_CS_LO +: 3];
    assign capture_filter_enable = timer_control_b[tmr_pkg::CTRL_B_FILTER];
    assign edge_rising = timer_control_b[tmr_pkg::CTRL_B_EDGE];
    assign wr_count = i_bus.wr && (i_bus.addr == tmr_pkg::ADDR_COUNT_LO);
    assign wr_capture = i_bus.wr && (i_bus.addr == tmr_pkg::ADDR_CAPT_LO) &&
                        capt_is_top(waveform_mode_field);  // see RL14

    // TOP selection by mode
    always_comb begin
        case (waveform_mode_field)  // see RL23
            4'h1, 4'h5: top_value = tmr_pkg::TOP_8BIT;
            4'h2, 4'h6: top_value = tmr_pkg::TOP_9BIT;
            4'h3, 4'h7: top_value = tmr_pkg::TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top_value = compare_a_value;
            4'h8, 4'hA, 4'hC, 4'hE: top_value = capture_value;
            default: top_value = tmr_pkg::COUNT_MAX;
        endcase
    end

    // Free-running prescaler, held at zero while powered off
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || timer_power_off_bit) begin
            prescale <= 10'h000;
        end else begin
            prescale <= prescale + 10'h001;
        end
    end

    // External clock pin synchroniser and edge history
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ext_sync <= 2'b00;
            ext_prev <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[0], i_ext_clock};
            ext_prev <= ext_sync[1];
        end
    end

    // Tick source select
    always_comb begin
        case (tmr_pkg::tmr_clock_sel_e'(clock_select_field))  // see RL2
            tmr_pkg::CS_DIV1:     timer_tick = 1'b1;
            tmr_pkg::CS_DIV8:     timer_tick =
                (prescale[2:0] == tmr_pkg::PRE_DIV8[2:0]);
            tmr_pkg::CS_DIV64:    timer_tick =
                (prescale[5:0] == tmr_pkg::PRE_DIV64[5:0]);
            tmr_pkg::CS_DIV256:   timer_tick =
                (prescale[7:0] == tmr_pkg::PRE_DIV256[7:0]);
            tmr_pkg::CS_DIV1024:  timer_tick =
                (prescale == tmr_pkg::PRE_DIV1024);
            tmr_pkg::CS_EXT_FALL: timer_tick = ext_prev && !ext_sync[1];
            tmr_pkg::CS_EXT_RISE: timer_tick = !ext_prev && ext_sync[1];
            default:              timer_tick = 1'b0;
        endcase
        if (timer_power_off_bit) begin
            timer_tick = 1'b0;  // see RL25
        end
    end

    // Next counter value and direction
    always_comb begin
        next_count = count_value;
        next_up = count_up;
        overflow_set = 1'b0;
        if (timer_tick) begin
            if (is_dual(waveform_mode_field)) begin
                if (count_up && count_value >= top_value) begin
                    next_count = count_value - 16'h0001;  // see RL3
                    next_up = 1'b0;
                end else if (!count_up && count_value == 16'h0000) begin
                    next_count = count_value + 16'h0001;
                    next_up = 1'b1;
                    overflow_set = 1'b1;  // see RL9
                end else if (count_up) begin
                    next_count = count_value + 16'h0001;
                end else begin
                    next_count = count_value - 16'h0001;
                end
            end else begin
                next_up = 1'b1;
                overflow_set = (count_value == tmr_pkg::COUNT_MAX) ||
                    (is_fast(waveform_mode_field) &&
                     count_value == top_value);  // see RL9
                next_count = (count_value == top_value) ? 16'h0000 :
                             count_value + 16'h0001;  // see RL3
            end
        end
        if (wr_count) begin
            next_count = {temp_high, i_bus.wdata};  // see RL5 see RL6 see RL7
        end
    end

    // Counter and direction registers
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            count_value <= tmr_pkg::VALUE_RESET;
            count_up <= 1'b1;
        end else begin
            count_value <= next_count;
            count_up <= next_up;
        end
    end

    // Extremes of the count sequence
    assign o_at_top = (count_value == top_value);  // see RL4
    assign o_at_bottom = (count_value == tmr_pkg::COUNT_BOT);  // see RL4

    // Capture source select and synchroniser
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            capt_sync <= 2'b00;
        end else begin
            capt_sync <= {capt_sync[0], comparator_capture_select ?
                i_comparator_output : i_capture_pin};  // see RL15 see RL18
        end
    end

    // Noise filter on the system clock
    assign filter_agree =
        (filter_hist == {(tmr_pkg::FILTER_SAMPLES-1){capt_sync[1]}});
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            filter_hist <= '0;
            filter_out <= 1'b0;
        end else begin
            filter_hist <= {filter_hist[tmr_pkg::FILTER_SAMPLES-3:0],
                            capt_sync[1]};  // see RL20
            if (filter_agree) begin
                filter_out <= capt_sync[1];  // see RL19
            end
        end
    end

    // Edge detector on filtered or plain source
    assign edge_src = capture_filter_enable ? filter_out :
                      capt_sync[1];  // see RL16
    assign capture_event = !timer_power_off_bit &&
        !capt_is_top(waveform_mode_field) &&  // see RL17
        (edge_rising ? (edge_src && !edge_prev) :
                       (!edge_src && edge_prev));  // see RL26
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            edge_prev <= 1'b0;
        end else begin
            edge_prev <= edge_src;
        end
    end

    // Capture value: every event overwrites
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            capture_value <= tmr_pkg::VALUE_RESET;
        end else if (capture_event) begin
            capture_value <= count_value;  // see RL10 see RL21
        end else if (wr_capture) begin
            capture_value <= {temp_high, i_bus.wdata};  // see RL14
        end
    end

    // Control and plain registers
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            timer_control_a <= tmr_pkg::CTRL_RESET;
            timer_control_b <= tmr_pkg::CTRL_RESET;
            compare_a_value <= tmr_pkg::VALUE_RESET;
            overflow_irq_enable <= 1'b0;
            capture_irq_enable <= 1'b0;
            comparator_capture_select <= 1'b0;
            timer_power_off_bit <= tmr_pkg::POWER_RESET;
        end else if (i_bus.wr) begin
            case (i_bus.addr)
                tmr_pkg::ADDR_CTRL_A: timer_control_a <= i_bus.wdata;
                tmr_pkg::ADDR_CTRL_B: timer_control_b <= i_bus.wdata;
                tmr_pkg::ADDR_CMPA_LO:
                    compare_a_value <= {temp_high, i_bus.wdata};
                tmr_pkg::ADDR_MASK: begin
                    overflow_irq_enable <= i_bus.wdata[tmr_pkg::FLAG_OVF];
                    capture_irq_enable <= i_bus.wdata[tmr_pkg::FLAG_CAPT];
                end
                tmr_pkg::ADDR_COMP_CTRL:
                    comparator_capture_select <=
                        i_bus.wdata[tmr_pkg::COMP_SEL];
                tmr_pkg::ADDR_POWER:
                    timer_power_off_bit <= i_bus.wdata[tmr_pkg::POWER_OFF];
                default: ;
            endcase
        end
    end

    // Shared temporary high byte
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            temp_high <= 8'h00;
        end else if (i_bus.wr && (i_bus.addr == tmr_pkg::ADDR_COUNT_HI ||
                     i_bus.addr == tmr_pkg::ADDR_CAPT_HI ||
                     i_bus.addr == tmr_pkg::ADDR_CMPA_HI)) begin
            temp_high <= i_bus.wdata;  // see RL1 see RL24
        end else if (i_bus.rd && i_bus.addr == tmr_pkg::ADDR_COUNT_LO) begin
            temp_high <= count_value[15:8];  // see RL5
        end else if (i_bus.rd && i_bus.addr == tmr_pkg::ADDR_CAPT_LO) begin
            temp_high <= capture_value[15:8];  // see RL13
        end
    end

    // Flags: hardware set wins over clear
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            overflow_flag <= 1'b0;
            capture_flag <= 1'b0;
        end else begin
            if (overflow_set) begin
                overflow_flag <= 1'b1;
            end else if (i_overflow_irq_ack || (i_bus.wr &&
                         i_bus.addr == tmr_pkg::ADDR_FLAGS &&
                         i_bus.wdata[tmr_pkg::FLAG_OVF])) begin
                overflow_flag <= 1'b0;
            end
            if (capture_event) begin
                capture_flag <= 1'b1;  // see RL11
            end else if (i_capture_irq_ack || (i_bus.wr &&
                         i_bus.addr == tmr_pkg::ADDR_FLAGS &&
                         i_bus.wdata[tmr_pkg::FLAG_CAPT])) begin
                capture_flag <= 1'b0;  // see RL12
            end
        end
    end

    // Interrupt requests
    assign o_overflow_irq = overflow_flag && overflow_irq_enable;  // see RL9
    assign o_capture_irq = capture_flag && capture_irq_enable;  // see RL12

    // Read data, valid the cycle after the strobe
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !i_bus.rd) begin
            o_rdata <= 8'h00;
        end else begin
            case (i_bus.addr)
                tmr_pkg::ADDR_CTRL_A:   o_rdata <= timer_control_a;
                tmr_pkg::ADDR_CTRL_B:   o_rdata <= timer_control_b;
                tmr_pkg::ADDR_COUNT_LO: o_rdata <= count_value[7:0];
                tmr_pkg::ADDR_CAPT_LO:  o_rdata <= capture_value[7:0];
                tmr_pkg::ADDR_COUNT_HI,
                tmr_pkg::ADDR_CAPT_HI:  o_rdata <= temp_high;  // see RL13
                tmr_pkg::ADDR_CMPA_LO:  o_rdata <= compare_a_value[7:0];
                tmr_pkg::ADDR_CMPA_HI:  o_rdata <= compare_a_value[15:8];
                tmr_pkg::ADDR_FLAGS:
                    o_rdata <= {2'b00, capture_flag, 4'h0, overflow_flag};
                tmr_pkg::ADDR_MASK:
                    o_rdata <= {2'b00, capture_irq_enable, 4'h0,
                                overflow_irq_enable};
                tmr_pkg::ADDR_COMP_CTRL:
                    o_rdata <= {5'h00, comparator_capture_select, 2'b00};
                tmr_pkg::ADDR_POWER:
                    o_rdata <= {7'h00, timer_power_off_bit};
                default: o_rdata <= 8'h00;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_write_wins: assert property (wr_count |=> // see RL6
        count_value == {$past(temp_high), $past(i_bus.wdata)})
        else $error("counter write did not load both bytes");
    a_stopped_holds: assert property ( // see RL2
        (clock_select_field == 3'h0 && !wr_count) |=> $stable(count_value))
        else $error("counter moved with no tick source");
    a_normal_step: assert property ( // see RL3
        (timer_tick && !wr_count && waveform_mode_field == 4'h0) |=>
        count_value == $past(count_value) + 16'h0001)
        else $error("normal mode did not step by one");
    a_capture_copy: assert property (capture_event |=> // see RL11
        capture_value == $past(count_value) && capture_flag)
        else $error("capture value or flag wrong after event");
    a_temp_latch: assert property ( // see RL5
        (i_bus.rd && i_bus.addr == tmr_pkg::ADDR_COUNT_LO) ##1
        (i_bus.rd && i_bus.addr == tmr_pkg::ADDR_COUNT_HI) |=>
        o_rdata == $past(count_value[15:8], 2))
        else $error("high byte read did not return latched value");
    a_filter_agree: assert property ( // see RL19
        !$stable(filter_out) |-> $past(filter_agree))
        else $error("filter changed without four agreeing samples");
    a_top_blocks: assert property ( // see RL17
        (capt_is_top(waveform_mode_field) && !wr_capture) |=>
        $stable(capture_value))
        else $error("capture value moved in a mode using it as top");
    a_flag_clear: assert property ( // see RL12
        (i_capture_irq_ack && !capture_event) |=> !capture_flag)
        else $error("capture flag not cleared by service");
    a_power_hold: assert property ( // see RL25
        (timer_power_off_bit && !wr_count) |=> $stable(count_value))
        else $error("counter moved while powered off");
    a_fixed_top: assert property ( // see RL23
        waveform_mode_field == 4'h5 |-> top_value == tmr_pkg::TOP_8BIT)
        else $error("fast 8-bit mode top wrong");

    c_capture: cover property (capture_event ##1 capture_flag);
    c_overflow: cover property (overflow_set);
    c_turn_down: cover property (count_up ##1 !count_up);
endmodule // tmr_timer16
`default_nettype wire
